// ===== rtl/conv0_regs_map.svh
// Purpose: Offsets, field positions, reset values and codes for the converter 0 register bank
// Assumes: Registers are byte wide, one per aligned 32-bit APB word
// Notes:   Register index times four gives the byte address
//
// Overview of operation
// - Part id bits 5-3, loaded from factory memory
// - Factory id bits 7-2, version bits 1-0
// - Bit 5 forces multiphase PWM, else auto phases
// - Bit 4 or bit 5 forces PWM, else PFM/PWM auto
// - Discharge when disabled only if bit 3; reset 1
// - Pin select ANDs enable with chosen input
// - Bit 0 switches converter on or off
// - Current limit changes apply while running
// - Control resets 8h and 1Ah, ids 0h
// - Slew rate bits 2-0, codes 0,1 reserved
`ifndef CONV0_REGS_MAP_SVH
`define CONV0_REGS_MAP_SVH

// Register indices and byte addresses
`define IDX_PART_IDENTIFICATION   4'h0
`define IDX_FACTORY_CONFIG_CODE   4'h1
`define IDX_CONVERTER0_CONTROL_A  4'h2
`define IDX_CONVERTER0_CONTROL_B  4'h3
`define ADDR_PART_IDENTIFICATION  12'h000
`define ADDR_FACTORY_CONFIG_CODE  12'h004
`define ADDR_CONVERTER0_CONTROL_A 12'h008
`define ADDR_CONVERTER0_CONTROL_B 12'h00c

// Reset values before factory defaults are applied
`define RST_PART_IDENTIFICATION   8'h00
`define RST_FACTORY_CONFIG_CODE   8'h00
`define RST_CONVERTER0_CONTROL_A  8'h08
`define RST_CONVERTER0_CONTROL_B  8'h1a
`define RST_CONV0_DISCHARGE       1'b1
`define RST_CONV0_ILIM            3'h3
`define RST_CONV0_SLEW            3'h2

// Field positions
`define POS_PART_IDENTIFIER       3
`define POS_FACTORY_CONFIG_ID     2
`define POS_FACTORY_CONFIG_VER    0
`define POS_CONV0_FORCE_MP        5
`define POS_CONV0_FORCE_PWM       4
`define POS_CONV0_DISCHARGE       3
`define POS_CONV0_PIN_SEL         1
`define POS_CONV0_ENABLE          0
`define POS_CONV0_ILIM            3
`define POS_CONV0_SLEW            0

// Writable masks of the control registers
`define MASK_CONVERTER0_CONTROL_A 8'h3f
`define MASK_CONVERTER0_CONTROL_B 8'h3f

// Reserved codes
`define ILIM_RESERVED_CODE        3'h7
`define SLEW_MIN_VALID_CODE       3'h2

`endif

// ===== rtl/conv0_regs_pkg.sv
// Purpose: Types shared by the converter 0 register bank
// Assumes: Constants live in conv0_regs_map.svh
// Notes:   Holds only types
package conv0_regs_pkg;

  // Effective enable source selection
  typedef enum logic [1:0] {
    SEL_BIT_ONLY,
    SEL_PIN_1,
    SEL_PIN_2,
    SEL_PIN_3
  } pin_sel_t;

  // Control register A fields
  typedef struct packed {
    logic [1:0] reserved;
    logic       force_multiphase;
    logic       force_pwm;
    logic       discharge_enable;
    pin_sel_t   pin_enable_select;
    logic       enable;
  } ctrl_a_t;

  // Control register B fields
  typedef struct packed {
    logic [1:0] reserved;
    logic [2:0] peak_current_limit;
    logic [2:0] slew_rate;
  } ctrl_b_t;

endpackage

// ===== rtl/conv0_enable_gate.sv
// Purpose: Resolves the effective converter enable from bit and pins
// Assumes: Pin inputs arrive already synchronised
// Notes:   Purely combinational, one clock domain outside
`timescale 1ns/1ps
`include "conv0_regs_map.svh"

module conv0_enable_gate (
  input  wire logic                    enable_bit,   // Software enable
  input  wire conv0_regs_pkg::pin_sel_t sel,         // Pin gating select
  input  wire logic [2:0]              pins_sync,    // Synchronised enable inputs 1..3
  output logic                         enable_eff    // Effective enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Select the gating pin and AND it with the bit
  always_comb begin
    case (sel)
      conv0_regs_pkg::SEL_BIT_ONLY: enable_eff = enable_bit;
      conv0_regs_pkg::SEL_PIN_1:    enable_eff = enable_bit & pins_sync[0];
      conv0_regs_pkg::SEL_PIN_2:    enable_eff = enable_bit & pins_sync[1];
      conv0_regs_pkg::SEL_PIN_3:    enable_eff = enable_bit & pins_sync[2];
      default:                      enable_eff = 1'b0;
    endcase
  end

endmodule

// ===== rtl/converter0_control_regs.sv
// Purpose: APB register bank for identification and converter 0 control
// Assumes: Single 40 MHz clock, asynchronous active-high reset
// Notes:   Factory defaults load once after reset release from FACTORY_* inputs
`timescale 1ns/1ps
`include "conv0_regs_map.svh"

module converter0_control_regs (
  input  wire logic        CLK,              // 40 MHz clock
  input  wire logic        RST,              // Async reset, active high
  input  wire logic        PSEL,             // APB select
  input  wire logic        PENABLE,          // APB access phase
  input  wire logic        PWRITE,           // APB direction
  input  wire logic [11:0] PADDR,            // APB byte address
  input  wire logic [31:0] PWDATA,           // APB write data
  input  wire logic [3:0]  PSTRB,            // APB byte strobes
  output logic      [31:0] PRDATA,           // APB read data
  output logic             PREADY,           // APB ready
  output logic             PSLVERR,          // APB error
  input  wire logic        FACTORY_VALID,    // Factory memory data valid
  input  wire logic [2:0]  FACTORY_PART_ID,  // Factory part identifier
  input  wire logic [5:0]  FACTORY_CFG_ID,   // Factory configuration id
  input  wire logic [1:0]  FACTORY_CFG_VER,  // Factory configuration version
  input  wire logic [7:0]  FACTORY_CTRL_A,   // Factory default control A
  input  wire logic [7:0]  FACTORY_CTRL_B,   // Factory default control B
  input  wire logic [2:0]  ENABLE_INPUT,     // Enable inputs 1..3 from pins
  output logic             CONV0_ON,         // Effective converter enable
  output logic             CONV0_DISCHARGE,  // Discharge resistor connected
  output logic             CONV0_FORCE_PWM,  // PWM only
  output logic             CONV0_FORCE_MP,   // Multiphase forced PWM
  output logic      [2:0]  CONV0_ILIM,       // Peak current limit code
  output logic      [2:0]  CONV0_SLEW        // Slew rate code
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]             part_identification;  // Id register
    logic [7:0]             factory_config_code;  // Factory code register
    conv0_regs_pkg::ctrl_a_t ctrl_a;               // Control A
    conv0_regs_pkg::ctrl_b_t ctrl_b;               // Control B
    logic                   loaded;               // Factory defaults taken
    logic [2:0]             pin_meta;             // First sync stage
    logic [2:0]             pin_sync;             // Second sync stage
    logic [31:0]            prdata;               // Read data
    logic                   pready;               // Ready
    logic                   pslverr;              // Error
    logic                   on;                   // Enable output
    logic                   discharge;            // Discharge output
    logic                   force_pwm;            // PWM output
    logic                   force_mp;             // Multiphase output
    logic [2:0]             ilim;                 // Limit output
    logic [2:0]             slew;                 // Slew output
  } state_t;

  state_t st;       // Registered state
  state_t next_st;  // Next state
  logic   en_eff;   // Effective enable from gate
  logic   access;   // Access phase edge
  logic   mapped;   // Address decodes to a register
  logic [7:0] rd_byte; // Selected read byte

  ////////////////////////////////////////////////////////////////////////////
  // Enable gating on synchronised pins
  conv0_enable_gate u_gate (
    .enable_bit (st.ctrl_a.enable),
    .sel        (st.ctrl_a.pin_enable_select),
    .pins_sync  (st.pin_sync),
    .enable_eff (en_eff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux
  always_comb begin
    access  = PSEL & PENABLE & ~st.pready;
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (PADDR)
      `ADDR_PART_IDENTIFICATION:  rd_byte = st.part_identification;
      `ADDR_FACTORY_CONFIG_CODE:  rd_byte = st.factory_config_code;
      `ADDR_CONVERTER0_CONTROL_A: rd_byte = st.ctrl_a;
      `ADDR_CONVERTER0_CONTROL_B: rd_byte = st.ctrl_b;
      default:                    mapped  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st          = st;
    next_st.pin_meta = ENABLE_INPUT;
    next_st.pin_sync = st.pin_meta;
    next_st.pready   = 1'b0;
    next_st.pslverr  = 1'b0;
    // Factory defaults once after reset; id fields and masked control defaults are taken, reserved stay zero
    if (!st.loaded && FACTORY_VALID) begin
      next_st.loaded = 1'b1;
      next_st.part_identification = {2'h0, FACTORY_PART_ID, 3'h0};
      next_st.factory_config_code = {FACTORY_CFG_ID, FACTORY_CFG_VER};
      next_st.ctrl_a = FACTORY_CTRL_A & `MASK_CONVERTER0_CONTROL_A;
      next_st.ctrl_b = FACTORY_CTRL_B & `MASK_CONVERTER0_CONTROL_B;
    end
    // APB access: one wait state, answer on the following edge
    if (access) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~mapped;
      next_st.prdata  = {24'h000000, rd_byte};
      if (PWRITE && PSTRB[0]) begin
        // Id registers ignore writes
        if (PADDR == `ADDR_CONVERTER0_CONTROL_A)
          next_st.ctrl_a = PWDATA[7:0] & `MASK_CONVERTER0_CONTROL_A;
        else if (PADDR == `ADDR_CONVERTER0_CONTROL_B)
          next_st.ctrl_b = PWDATA[7:0] & `MASK_CONVERTER0_CONTROL_B;
      end
    end
    // Drive outputs from registered fields; limit applies without disable
    next_st.on        = en_eff;
    next_st.discharge = ~en_eff & st.ctrl_a.discharge_enable;
    next_st.force_pwm = st.ctrl_a.force_pwm | st.ctrl_a.force_multiphase;
    next_st.force_mp  = st.ctrl_a.force_multiphase;
    // Reserved limit code holds the previous limit
    if (st.ctrl_b.peak_current_limit != `ILIM_RESERVED_CODE)
      next_st.ilim = st.ctrl_b.peak_current_limit;
    // Reserved slew codes hold the previous rate
    if (st.ctrl_b.slew_rate >= `SLEW_MIN_VALID_CODE)
      next_st.slew = st.ctrl_b.slew_rate;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, reset to documented values
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st                     <= '0;
      st.part_identification <= `RST_PART_IDENTIFICATION;
      st.factory_config_code <= `RST_FACTORY_CONFIG_CODE;
      st.ctrl_a              <= `RST_CONVERTER0_CONTROL_A;
      st.ctrl_b              <= `RST_CONVERTER0_CONTROL_B;
      st.discharge           <= `RST_CONV0_DISCHARGE;
      st.ilim                <= `RST_CONV0_ILIM;
      st.slew                <= `RST_CONV0_SLEW;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA          = st.prdata;
  assign PREADY          = st.pready;
  assign PSLVERR         = st.pslverr;
  assign CONV0_ON        = st.on;
  assign CONV0_DISCHARGE = st.discharge;
  assign CONV0_FORCE_PWM = st.force_pwm;
  assign CONV0_FORCE_MP  = st.force_mp;
  assign CONV0_ILIM      = st.ilim;
  assign CONV0_SLEW      = st.slew;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_id_reserved_zero: assert property (st.part_identification[7:6] == 2'h0 && st.part_identification[2:0] == 3'h0)
    else $error("Part id reserved bits not zero");
  a_factory_load: assert property (!st.loaded && FACTORY_VALID |=> st.factory_config_code == $past({FACTORY_CFG_ID, FACTORY_CFG_VER}))
    else $error("Factory code not loaded");
  a_multiphase_out: assert property (st.ctrl_a.force_multiphase |=> CONV0_FORCE_MP && CONV0_FORCE_PWM)
    else $error("Multiphase not forced");
  a_pwm_out: assert property (st.ctrl_a.force_pwm |=> CONV0_FORCE_PWM)
    else $error("PWM not forced");
  a_discharge_off: assert property (CONV0_ON |-> !CONV0_DISCHARGE)
    else $error("Discharge while enabled");
  a_pin_gate: assert property (st.ctrl_a.pin_enable_select == conv0_regs_pkg::SEL_PIN_1 && !st.pin_sync[0] |=> !CONV0_ON)
    else $error("Pin 1 gating ignored");
  a_bit_only: assert property (st.ctrl_a.pin_enable_select == conv0_regs_pkg::SEL_BIT_ONLY |=> CONV0_ON == $past(st.ctrl_a.enable))
    else $error("Enable bit not followed");
  a_ilim_valid: assert property (CONV0_ILIM != `ILIM_RESERVED_CODE)
    else $error("Reserved limit applied");
  a_ilim_live: assert property (access && PWRITE && PSTRB[0] && PADDR == `ADDR_CONVERTER0_CONTROL_B && PWDATA[5:3] != 3'h7 |-> ##2 CONV0_ILIM == $past(PWDATA[5:3], 2))
    else $error("Limit change not applied");
  a_slew_valid: assert property (CONV0_SLEW >= `SLEW_MIN_VALID_CODE)
    else $error("Reserved slew applied");
  a_ro_write: assert property (access && PWRITE && PADDR == `ADDR_PART_IDENTIFICATION |=> $stable(st.part_identification))
    else $error("Id register written");
  c_write_a: cover property (access && PWRITE && PADDR == `ADDR_CONVERTER0_CONTROL_A);
  c_read_id: cover property (access && !PWRITE && PADDR == `ADDR_PART_IDENTIFICATION);
  c_unmapped: cover property (PREADY && PSLVERR);
  c_conv_on: cover property ($rose(CONV0_ON));

endmodule

// ===== test/converter0_control_regs_bench.sv
// Purpose: Self-checking bench for the converter 0 register bank over APB
// Assumes: One wait state per APB access, outputs lag registers by one cycle, pins by three
// Notes:   Factory valid is raised after the reset reads and held; only the first load is taken, so later writes stay
`timescale 1ns/1ps
`include "conv0_regs_map.svh"

module converter0_control_regs_bench;
  logic        clk, rst, psel, penable, pwrite, pslverr, pready, fvalid;  // Clock, reset, APB control
  logic [11:0] paddr;                                 // APB byte address
  logic [31:0] pwdata, prdata, rd;                    // APB data and last read
  logic [3:0]  pstrb;                                 // APB strobes
  logic [2:0]  fpart, pins, ilim, slew;               // Factory part id, enable pins, limit and slew codes
  logic [5:0]  fcid;                                  // Factory configuration id
  logic [1:0]  fver;                                  // Factory configuration version
  logic [7:0]  fca, fcb;                              // Factory control defaults
  logic        on, dis, fpwm, fmp;                    // Converter control outputs
  int          err_count, checks_done, cycles;        // Report counters and timeout count

  converter0_control_regs uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FACTORY_VALID(fvalid), .FACTORY_PART_ID(fpart), .FACTORY_CFG_ID(fcid), .FACTORY_CFG_VER(fver),
    .FACTORY_CTRL_A(fca), .FACTORY_CTRL_B(fcb), .ENABLE_INPUT(pins), .CONV0_ON(on),
    .CONV0_DISCHARGE(dis), .CONV0_FORCE_PWM(fpwm), .CONV0_FORCE_MP(fmp), .CONV0_ILIM(ilim),
    .CONV0_SLEW(slew));

  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;

  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and bus tasks

  // Case-equality compare so an unknown never matches
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic exp_err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    check("pslverr", {31'h0, exp_err}, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Read a register and compare its word
  task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0, 4'h0, 1'b0);
    check(name, {24'h0, exp}, rd);
  endtask

  // Compare the converter outputs except slew after the lag has passed
  task automatic out_chk(input logic [7:0] exp);
    repeat (4) @(posedge clk);
    check("outputs", {24'h0, exp}, {24'h0, on, dis, fpwm, fmp, 1'b0, ilim});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios

  // Values before factory load, then the factory load itself
  task automatic t_reset_factory();
    rd_chk("part_identification", `ADDR_PART_IDENTIFICATION, 8'h00);
    rd_chk("factory_config_code", `ADDR_FACTORY_CONFIG_CODE, 8'h00);
    rd_chk("control_a", `ADDR_CONVERTER0_CONTROL_A, 8'h08);
    rd_chk("control_b", `ADDR_CONVERTER0_CONTROL_B, 8'h1a);
    check("slew", 32'h2, {29'h0, slew});
    out_chk(8'h43);
    fvalid <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk("part_identifier", `ADDR_PART_IDENTIFICATION, 8'h28);
    rd_chk("factory_config", `ADDR_FACTORY_CONFIG_CODE, 8'hae);
    rd_chk("control_a", `ADDR_CONVERTER0_CONTROL_A, 8'h08);
    rd_chk("control_b", `ADDR_CONVERTER0_CONTROL_B, 8'h1c);
    check("slew", 32'h4, {29'h0, slew});
  endtask

  // Read-only writes, masked strobe and unmapped address leave everything alone
  task automatic t_refused();
    apb(1'b1, `ADDR_PART_IDENTIFICATION, 32'hff, 4'hf, 1'b0);
    apb(1'b1, `ADDR_FACTORY_CONFIG_CODE, 32'h00, 4'hf, 1'b0);
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_A, 32'h01, 4'h0, 1'b0);
    apb(1'b1, 12'h010, 32'h01, 4'hf, 1'b1);
    rd_chk("part_identifier", `ADDR_PART_IDENTIFICATION, 8'h28);
    rd_chk("factory_config", `ADDR_FACTORY_CONFIG_CODE, 8'hae);
    rd_chk("control_a", `ADDR_CONVERTER0_CONTROL_A, 8'h08);
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_A, 32'hff, 4'h1, 1'b0);
    rd_chk("control_a", `ADDR_CONVERTER0_CONTROL_A, 8'h3f);
  endtask

  // Every pin select code with its own pin high, then with the other pins high
  task automatic t_pin_gating();
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_A, 32'h09, 4'h1, 1'b0);
    out_chk(8'h83);
    for (int k = 1; k < 4; k++) begin
      pins <= 3'h1 << (k - 1);
      apb(1'b1, `ADDR_CONVERTER0_CONTROL_A, 32'h09 | (k << 1), 4'h1, 1'b0);
      out_chk(8'h83);
      pins <= ~(3'h1 << (k - 1));
      out_chk(8'h43);
    end
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_A, 32'h00, 4'h1, 1'b0);
    out_chk(8'h03);
  endtask

  // Mode forcing and limit changes while the converter runs
  task automatic t_modes_limits();
    pins <= 3'h0;
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_A, 32'h11, 4'h1, 1'b0);
    out_chk(8'ha3);
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_A, 32'h21, 4'h1, 1'b0);
    out_chk(8'hb3);
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_B, 32'h37, 4'h1, 1'b0);
    rd_chk("control_b", `ADDR_CONVERTER0_CONTROL_B, 8'h37);
    out_chk(8'hb6);
    check("slew", 32'h7, {29'h0, slew});
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_B, 32'h39, 4'h1, 1'b0);
    out_chk(8'hb6);
    check("slew", 32'h7, {29'h0, slew});
    apb(1'b1, `ADDR_CONVERTER0_CONTROL_B, 32'h02, 4'h1, 1'b0);
    out_chk(8'hb0);
    check("slew", 32'h2, {29'h0, slew});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence

  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0;
    fvalid = 0; fpart = 3'h5; fcid = 6'h2b; fver = 2'h2; fca = 8'hc8; fcb = 8'hdc; pins = 3'h0;
    err_count = 0; checks_done = 0; cycles = 0; rd = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_factory();
    t_refused();
    t_pin_gating();
    t_modes_limits();
    stop_test();
  end
endmodule
